//--- hdl/dual_comparator_control.v
`include "cmp_ctrl_defs.vh"
module dual_comparator_control (
  input  wire                 i_ref_clk,
  input  wire                 i_rst_n,
  input  wire [`ADDR_W-1:0]   i_addr,
  input  wire [7:0]           i_wdata,
  input  wire                 i_wr,
  input  wire                 i_rd,
  output reg  [7:0]           o_rdata,
  input  wire                 i_pos_a_one,
  input  wire                 i_pos_b_one,
  input  wire                 i_pos_a_two,
  input  wire                 i_pos_b_two,
  input  wire                 i_ext_ref,
  input  wire                 i_int_ref,
  input  wire                 i_comparator_irq_enable,
  input  wire                 i_global_irq_enable,
  input  wire                 i_total_power_down,
  input  wire                 i_aux_power_down,
  output reg                  o_pin_one,
  output reg                  o_pin_two,
  output reg                  o_irq,
  output reg                  o_wake,
  output reg                  o_analog_power_on,
  output reg                  o_settled_one,
  output reg                  o_settled_two
);
  // ========================================================================
  // register state
  reg  [3:0] cfg_one;
  reg  [3:0] cfg_two;
  reg        en_one;
  reg        en_two;
  wire       act_one;
  wire       act_two;
  wire       sel_one;
  wire       sel_two;
  wire       wr_one;
  wire       wr_two;
  wire       rd_one;
  wire       rd_two;

  // channel results
  wire       pin_one;
  wire       pin_two;
  wire       sync_one;
  wire       sync_two;
  wire       flag_one;
  wire       flag_two;
  wire       clr_one;
  wire       clr_two;
  wire       settled_one;
  wire       settled_two;
  wire       any_flag;
  wire       any_active;
  wire [7:0] word_one;
  wire [7:0] word_two;

  // next values of the registered outputs
  reg  [7:0] next_rdata;
  reg        next_irq;
  reg        next_wake;
  reg        next_power_on;
  reg        next_pin_one;
  reg        next_pin_two;
  reg        next_settled_one;
  reg        next_settled_two;

  // ========================================================================
  // decoding helpers
  function hits;
    input [`ADDR_W-1:0] addr;
    input [`ADDR_W-1:0] target;
    begin
      hits = (addr == target);
    end
  endfunction

  // read layout: reserved, enable, pos, neg, pin oe, sync, flag
  function [7:0] pack;
    input       en;
    input [3:0] cfg;
    input       sync;
    input       flag;
    begin
      pack               = {`RSVD_READ, 6'h00};
      pack[`BIT_ENABLE]  = en;
      pack[`BIT_POS_SEL] = cfg[3];
      pack[`BIT_NEG_SEL] = cfg[2];
      pack[`BIT_PIN_OE]  = cfg[1];
      pack[`BIT_SYNC]    = sync;
      pack[`BIT_FLAG]    = flag;
    end
  endfunction

  // the sync slot of a stored cfg stays zero; the live result fills it
  function [3:0] cfg_of;
    input [7:0] wdata;
    begin
      cfg_of    = 4'h0;
      cfg_of[3] = wdata[`BIT_POS_SEL];
      cfg_of[2] = wdata[`BIT_NEG_SEL];
      cfg_of[1] = wdata[`BIT_PIN_OE];
    end
  endfunction

  // one-hot pick; anything else, unmapped included, reads zero
  function [7:0] read_mux;
    input       hit_one;
    input       hit_two;
    input [7:0] word_a;
    input [7:0] word_b;
    begin
      case ({hit_two, hit_one})
        2'b01:   read_mux = word_a;
        2'b10:   read_mux = word_b;
        default: read_mux = 8'h00;
      endcase
    end
  endfunction

  // bus strobes qualified by the address
  assign sel_one = hits(i_addr, `ADDR_CMP_ONE);
  assign sel_two = hits(i_addr, `ADDR_CMP_TWO);
  assign wr_one  = i_wr & sel_one;
  assign wr_two  = i_wr & sel_two;
  assign rd_one  = i_rd & sel_one;
  assign rd_two  = i_rd & sel_two;

  // total power-down forces both comparators off
  assign act_one    = en_one & ~i_total_power_down;
  assign act_two    = en_two & ~i_total_power_down;
  assign any_active = act_one | act_two;

  // writing a zero to the flag clears it; writing one leaves it alone
  assign clr_one  = wr_one & ~i_wdata[`BIT_FLAG];
  assign clr_two  = wr_two & ~i_wdata[`BIT_FLAG];
  assign any_flag = flag_one | flag_two;

  // read words, built whole so the read mux only picks one
  assign word_one = pack(en_one, cfg_one, sync_one, flag_one);
  assign word_two = pack(en_two, cfg_two, sync_two, flag_two);

  // ========================================================================
  // register writes: reserved bits 7 and 6 are never stored; each field
  // group has its own process so a write to one register never disturbs
  // the other
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_one <= `CFG_RESET;
    end else if (wr_one) begin
      cfg_one <= cfg_of(i_wdata);
    end
  end

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_one <= 1'b0;
    end else if (wr_one) begin
      en_one <= i_wdata[`BIT_ENABLE];
    end
  end

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_two <= `CFG_RESET;
    end else if (wr_two) begin
      cfg_two <= cfg_of(i_wdata);
    end
  end

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_two <= 1'b0;
    end else if (wr_two) begin
      en_two <= i_wdata[`BIT_ENABLE];
    end
  end

  // ========================================================================
  // channels; the sync bit slot in cfg is unused by the channel
  cmp_channel u_one (
    .i_ref_clk    (i_ref_clk),
    .i_rst_n      (i_rst_n),
    .i_cfg        ({cfg_one[3:1], 1'b0}),
    .i_enable     (act_one),
    .i_pos_a      (i_pos_a_one),
    .i_pos_b      (i_pos_b_one),
    .i_ext_ref    (i_ext_ref),
    .i_int_ref    (i_int_ref),
    .i_flag_clear (clr_one),
    .o_raw        (),
    .o_pin        (pin_one),
    .o_sync       (sync_one),
    .o_flag       (flag_one),
    .o_settled    (settled_one)
  );

  cmp_channel u_two (
    .i_ref_clk    (i_ref_clk),
    .i_rst_n      (i_rst_n),
    .i_cfg        ({cfg_two[3:1], 1'b0}),
    .i_enable     (act_two),
    .i_pos_a      (i_pos_a_two),
    .i_pos_b      (i_pos_b_two),
    .i_ext_ref    (i_ext_ref),
    .i_int_ref    (i_int_ref),
    .i_flag_clear (clr_two),
    .o_raw        (),
    .o_pin        (pin_two),
    .o_sync       (sync_two),
    .o_flag       (flag_two),
    .o_settled    (settled_two)
  );

  // ========================================================================
  // next values
  // reads of an unmapped address return zero
  always @* begin
    next_rdata = read_mux(rd_one, rd_two, word_one, word_two);
  end

  // raw result to the pin, gated by enable and pin oe in the channel
  always @* begin
    next_pin_one = pin_one;
    next_pin_two = pin_two;
  end

  // shared request needs both enables and either flag
  always @* begin
    next_irq = i_comparator_irq_enable & i_global_irq_enable
               & any_flag;
  end

  // wake ignores the global enable but never fires in total power-down
  always @* begin
    next_wake = i_comparator_irq_enable & any_flag
                & ~i_total_power_down;
  end

  // outside total power-down, analog is powered while any comparator is on or aux bit is clear
  always @* begin
    next_power_on = ~i_total_power_down
                    & (any_active | ~i_aux_power_down);
  end

  // settled only reports; the flag is never masked meanwhile
  always @* begin
    next_settled_one = settled_one;
    next_settled_two = settled_two;
  end

  // ========================================================================
  // outputs, all registered; the pin adds one flop of delay to the raw
  // result, traded for the registered-output house style
  // read data stands one cycle, then returns to zero
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pin_one <= 1'b0;
    end else begin
      o_pin_one <= next_pin_one;
    end
  end

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pin_two <= 1'b0;
    end else begin
      o_pin_two <= next_pin_two;
    end
  end

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= next_irq;
    end
  end

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wake <= 1'b0;
    end else begin
      o_wake <= next_wake;
    end
  end

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_analog_power_on <= 1'b0;
    end else begin
      o_analog_power_on <= next_power_on;
    end
  end

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_settled_one <= 1'b0;
    end else begin
      o_settled_one <= next_settled_one;
    end
  end

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_settled_two <= 1'b0;
    end else begin
      o_settled_two <= next_settled_two;
    end
  end
endmodule

//--- hdl/cmp_ctrl_defs.vh
`ifndef CMP_CTRL_DEFS_VH
`define CMP_CTRL_DEFS_VH
// ==========================================================================
// register map
`define ADDR_W          8
`define ADDR_CMP_ONE    8'hac
`define ADDR_CMP_TWO    8'had
// ==========================================================================
// control register fields
`define BIT_FLAG        0
`define BIT_SYNC        1
`define BIT_PIN_OE      2
`define BIT_NEG_SEL     3
`define BIT_POS_SEL     4
`define BIT_ENABLE      5
`define RSVD_READ       2'b00
`define CFG_RESET       4'h0
// ==========================================================================
// timing
`define SETTLE_NS       10000
`define CLK_PERIOD_NS   100
`define SETTLE_CYCLES   ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

//--- hdl/result_sync.v
`include "cmp_ctrl_defs.vh"
// ==========================================================================
// three-stage synchroniser; a change counts when stages two and three agree
module result_sync (
  input  wire i_ref_clk,
  input  wire i_rst_n,
  input  wire i_async,
  output reg  o_sync
);
  reg meta;
  reg stage2;
  reg stage3;

  // reset value 1 matches a disabled comparator's forced-high result
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta   <= 1'b1;
      stage2 <= 1'b1;
      stage3 <= 1'b1;
      o_sync <= 1'b1;
    end else begin
      meta   <= i_async;
      stage2 <= meta;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        o_sync <= stage3;
      end
    end
  end
endmodule

//--- hdl/cmp_channel.v
`include "cmp_ctrl_defs.vh"
// ==========================================================================
// one comparator's digital side: input select, forced-high, pin mux, flag
module cmp_channel (
  input  wire       i_ref_clk,
  input  wire       i_rst_n,
  input  wire [3:0] i_cfg,
  input  wire       i_enable,
  input  wire       i_pos_a,
  input  wire       i_pos_b,
  input  wire       i_ext_ref,
  input  wire       i_int_ref,
  input  wire       i_flag_clear,
  output wire       o_raw,
  output wire       o_pin,
  output wire       o_sync,
  output reg        o_flag,
  output reg        o_settled
);
  localparam integer SETTLE_I = `SETTLE_CYCLES;
  localparam [13:0]  SETTLE   = SETTLE_I[13:0];
  wire pos_pin;
  wire neg_pin;
  wire synced;
  reg  sync_d;
  reg  [13:0] settle_cnt;

  // the analog core's decision is modelled as which selected input is high
  assign pos_pin = i_cfg[`BIT_POS_SEL - 1] ? i_pos_b : i_pos_a;
  assign neg_pin = i_cfg[`BIT_NEG_SEL - 1] ? i_int_ref : i_ext_ref;
  // a disabled comparator reads high
  assign o_raw = i_enable ? (pos_pin & ~neg_pin) : 1'b1;
  // raw result, not synchronised; pin is asynchronous to the cpu clock
  assign o_pin = i_enable & i_cfg[`BIT_PIN_OE - 1] & o_raw;

  result_sync u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (o_raw),
    .o_sync    (synced)
  );
  assign o_sync = synced;

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_d     <= 1'b1;
      o_flag     <= 1'b0;
      settle_cnt <= 14'h0000;
      o_settled  <= 1'b0;
    end else begin
      sync_d <= synced;
      if (sync_d != synced) begin
        o_flag <= 1'b1;
      end else if (i_flag_clear) begin
        o_flag <= 1'b0;
      end
      // settling indicator only; the flag is not masked meanwhile
      if (!i_enable) begin
        settle_cnt <= 14'h0000;
        o_settled  <= 1'b0;
      end else if (settle_cnt < SETTLE) begin
        settle_cnt <= settle_cnt + 14'h0001;
      end else begin
        o_settled <= 1'b1;
      end
    end
  end
endmodule

//--- bench/analog_inputs.sv
// ====
// analog pins: digital stand-ins driven as levels by the bench
module analog_inputs (
  input  wire logic [5:0] i_level,
  output wire logic       o_pos_a_one,
  output wire logic       o_pos_b_one,
  output wire logic       o_pos_a_two,
  output wire logic       o_pos_b_two,
  output wire logic       o_ext_ref,
  output wire logic       o_int_ref
);
  timeunit 1ns;
  timeprecision 1ns;
  // pins are never released, so no idle pattern is needed
  assign {o_int_ref, o_ext_ref, o_pos_b_two, o_pos_a_two, o_pos_b_one,
          o_pos_a_one} = i_level;
endmodule

//--- bench/cmp_ctrl_assertions.sv
// ====
// port checker
module cmp_ctrl_checker (
  input wire logic       i_ref_clk,
  input wire logic       i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       i_comparator_irq_enable,
  input wire logic       i_global_irq_enable,
  input wire logic       i_total_power_down,
  input wire logic       i_aux_power_down,
  input wire logic       o_pin_one,
  input wire logic       o_pin_two,
  input wire logic       o_irq,
  input wire logic       o_wake,
  input wire logic       o_analog_power_on,
  input wire logic       o_settled_one,
  input wire logic       o_settled_two
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not idle");
  chk_rsvd_zero: assert property ($past(i_rd) |-> o_rdata[7:6] == 2'b00)
    else $error("reserved bits not zero");
  chk_unmapped_zero: assert property ($past(i_rd) && $past(i_addr) != 8'hac
    && $past(i_addr) != 8'had |-> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_irq_gated: assert property (o_irq |-> $past(i_comparator_irq_enable)
    && $past(i_global_irq_enable)) else $error("irq without enables");
  chk_wake_enabled: assert property (o_wake |-> $past(i_comparator_irq_enable))
    else $error("wake without irq enable");
  chk_wake_no_tpd: assert property (o_wake |-> !$past(i_total_power_down))
    else $error("wake in total power-down");
  chk_tpd_power_off: assert property ($past(i_total_power_down)
    |-> !o_analog_power_on) else $error("analog powered in total power-down");
  chk_aux_power_on: assert property ($past(i_rst_n) && !$past(i_aux_power_down)
    && !$past(i_total_power_down) |-> o_analog_power_on)
    else $error("analog not powered");
  chk_tpd_pin_low: assert property ($past(i_total_power_down, 2)
    && $past(i_total_power_down) |-> !o_pin_one && !o_pin_two)
    else $error("pin driven in total power-down");
  chk_tpd_unsettled: assert property ($past(i_total_power_down, 2)
    && $past(i_total_power_down) |-> !o_settled_one && !o_settled_two)
    else $error("settled in total power-down");
endmodule
bind dual_comparator_control cmp_ctrl_checker u_chk (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_comparator_irq_enable(i_comparator_irq_enable),
  .i_global_irq_enable(i_global_irq_enable),
  .i_total_power_down(i_total_power_down),
  .i_aux_power_down(i_aux_power_down), .o_pin_one(o_pin_one),
  .o_pin_two(o_pin_two), .o_irq(o_irq), .o_wake(o_wake),
  .o_analog_power_on(o_analog_power_on), .o_settled_one(o_settled_one),
  .o_settled_two(o_settled_two));

//--- bench/testbench.sv
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  n_errors++; $display("mismatch %s exp %h got %h", n, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // ====
  // stimulus, partner and design
  logic clk = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0, cie = 1'b0;
  logic gie = 1'b0, tpd = 1'b0, aux = 1'b0, r;
  logic [7:0] addr = 8'h00, wdata = 8'h00, a;
  logic [5:0] lvl = 6'h00;
  logic [2:0] cc;
  wire [7:0] rdata;
  wire pa1, pb1, pa2, pb2, er, ir, pin1, pin2, irq, wake, pwr, st1, st2;
  int n_errors = 0, total_checks = 0;
  initial forever #50 clk = ~clk;
  analog_inputs u_ana (.i_level(lvl), .o_pos_a_one(pa1), .o_pos_b_one(pb1),
    .o_pos_a_two(pa2), .o_pos_b_two(pb2), .o_ext_ref(er), .o_int_ref(ir));
  dual_comparator_control u_dut (.i_ref_clk(clk), .i_rst_n(rst_n),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s),
    .o_rdata(rdata), .i_pos_a_one(pa1), .i_pos_b_one(pb1),
    .i_pos_a_two(pa2), .i_pos_b_two(pb2), .i_ext_ref(er), .i_int_ref(ir),
    .i_comparator_irq_enable(cie), .i_global_irq_enable(gie),
    .i_total_power_down(tpd), .i_aux_power_down(aux), .o_pin_one(pin1),
    .o_pin_two(pin2), .o_irq(irq), .o_wake(wake), .o_analog_power_on(pwr),
    .o_settled_one(st1), .o_settled_two(st2));
  // ====
  // helpers: result = selected positive above selected negative
  function automatic logic res(input int ch, input logic [2:0] c);
    return (c[2] ? lvl[2*ch+1] : lvl[2*ch]) & ~(c[1] ? lvl[5] : lvl[4]);
  endfunction
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    addr <= ad;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] ad, input logic [7:0] e);
    @(posedge clk);
    addr <= ad;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    `CHK("ctrl", e, rdata)
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ====
  // tests
  initial begin
    void'($urandom(32'h96792c9a));
    tk(6);
    rst_n <= 1'b1;
    rd_chk(8'hac, 8'h02);
    rd_chk(8'had, 8'h02);
    rd_chk(8'hae, 8'h00);
    $display("test reset done");
    for (int ch = 0; ch < 2; ch++) begin
      for (int c = 0; c < 8; c++) begin
        cc = 3'(c);
        a = 8'hac + 8'(ch);
        @(posedge clk);
        lvl <= 6'($urandom);
        wr(a, {3'b111, cc, 2'b10}); // reserved and read-only bits set
        tk(8);
        wr(a, {3'b111, cc, 2'b10}); // second write clears the flag
        tk(2);
        #1;
        r = res(ch, cc);
        rd_chk(a, {3'b001, cc, r, 1'b0});
        `CHK("pin", cc[0] & r, ch ? pin2 : pin1)
        @(posedge clk);
        lvl[2*ch+cc[2]] <= ~lvl[2*ch+cc[2]];
        tk(8);
        #1;
        rd_chk(a, {3'b001, cc, res(ch, cc), res(ch, cc) != r});
      end
    end
    $display("test config done");
    wr(8'had, 8'h00);
    @(posedge clk);
    lvl <= 6'h00;
    wr(8'hac, 8'h20);
    tk(8);
    wr(8'hac, 8'h20);
    wr(8'had, 8'h00);
    rd_chk(8'hac, 8'h20);
    wr(8'hac, 8'h00); // disabling with a low result must raise the flag
    tk(8);
    rd_chk(8'hac, 8'h03);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      cie <= k[0];
      gie <= k[1];
      tk(3);
      #1;
      `CHK("irq", k == 3, irq)
      `CHK("wake", k[0], wake)
    end
    rd_chk(8'had, 8'h02);
    wr(8'hac, 8'h00);
    tk(3);
    #1;
    `CHK("irq", 1'b0, irq)
    $display("test irq done");
    @(posedge clk);
    cie <= 1'b0;
    gie <= 1'b0;
    aux <= 1'b1;
    tk(3);
    #1;
    `CHK("power", 1'b0, pwr)
    @(posedge clk);
    aux <= 1'b0;
    tk(3);
    #1;
    `CHK("power", 1'b1, pwr)
    wr(8'hac, 8'h24);
    tk(95);
    #1;
    `CHK("settled", 1'b0, st1)
    tk(10);
    #1;
    `CHK("settled", 1'b1, st1)
    @(posedge clk);
    lvl <= 6'h01;
    tk(8);
    #1;
    `CHK("pin", 1'b1, pin1)
    @(posedge clk);
    cie <= 1'b1;
    tpd <= 1'b1;
    tk(8);
    #1;
    `CHK("pin", 1'b0, pin1)
    `CHK("wake", 1'b0, wake)
    `CHK("power", 1'b0, pwr)
    `CHK("settled", 1'b0, st2)
    $display("test power done");
    finish_test;
  end
  // hang guard: the tests need well under 2000 cycles
  initial begin
    tk(4000);
    n_errors++;
    finish_test;
  end
endmodule
